// [design/pcs_pkg.sv]
// constants and code tables shared by the coding sublayer
package pcs_pkg;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          STABLE_TIME_US = 64;
  localparam int          STABLE_CYCLES  = STABLE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          RX_FIFO_DEPTH  = 8;
  localparam logic [3:0]  BIT_LAST       = 4'h9;
  localparam logic [9:0]  COMMA_NEG      = 10'h0FA;
  localparam logic [9:0]  COMMA_POS      = 10'h305;
  localparam logic [4:0]  K28_LOW        = 5'h1C;
  localparam logic [5:0]  K28_6B         = 6'h0F;
  localparam logic [5:0]  D7_6B          = 6'h38;
  localparam logic [3:0]  X3_4B          = 4'hC;
  localparam logic [3:0]  A7_4B          = 4'h7;
  localparam logic [2:0]  X7_HIGH        = 3'h7;
  // rx clock divider: slow stands for the reference rate, fast for the data rate
  localparam logic [2:0]  RCLK_SLOW_PER  = 3'h5;
  localparam logic [2:0]  RCLK_SLOW_HI   = 3'h2;
  localparam logic [2:0]  RCLK_FAST_PER  = 3'h2;
  localparam logic [2:0]  RCLK_FAST_HI   = 3'h1;
  // bit positions of the sampled transmit pin group
  localparam int          TXS_CLK        = 11;
  localparam int          TXS_K          = 10;
  localparam int          TXS_BYTE       = 2;
  localparam int          TXS_IDLE       = 1;
  localparam int          TXS_COMP       = 0;
  // 5b/6b and 3b/4b codes for negative running disparity, abcdei / fghj
  localparam logic [31:0][5:0] TBL6 = {
    6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
  localparam logic [7:0][3:0] TBL4 = {
    4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
endpackage

// [design/code_word_if.sv]
// byte to symbol carrier between the datapath and its coders
`timescale 1ns/100ps
interface code_word_if;
  logic [7:0] data;
  logic       k;
  logic       rd;
  logic [9:0] sym;
  logic       rd_next;
  logic       bad;
  modport enc (input data, k, rd, output sym, rd_next);
  modport dec (input sym, output data, k, bad);
endinterface

// [design/pcs_encoder.sv]
// 8b/10b encoder with running disparity in and out
`timescale 1ns/100ps
module pcs_encoder (
  code_word_if.enc c
);
  logic [5:0] s6;
  logic [5:0] c6;
  logic [3:0] s4;
  logic       rd_mid;
  logic       ub6;
  logic       ub4;

  always_comb begin
    s6 = pcs_pkg::TBL6[c.data[4:0]];
    if (c.k && c.data[4:0] == pcs_pkg::K28_LOW) begin
      s6 = pcs_pkg::K28_6B;
    end
    ub6    = $countones(s6) != 3;
    c6     = (c.rd && (ub6 || s6 == pcs_pkg::D7_6B)) ? ~s6 : s6;
    rd_mid = ub6 ? ~c.rd : c.rd;
    s4     = pcs_pkg::TBL4[c.data[7:5]];
    // alternate x.7 avoids a run of five
    if (c.data[7:5] == pcs_pkg::X7_HIGH &&
        (c.k || (!rd_mid && c6[1:0] == 2'h3) || (rd_mid && c6[1:0] == 2'h0))) begin
      s4 = pcs_pkg::A7_4B;
    end
    ub4 = $countones(s4) != 2;
    if (ub4 || s4 == pcs_pkg::X3_4B) begin
      c.sym = {c6, rd_mid ? ~s4 : s4};
    end else begin
      c.sym = {c6, (c.k && !rd_mid) ? ~s4 : s4};
    end
    c.rd_next = ub4 ? ~rd_mid : rd_mid;
  end
endmodule

// [design/pcs_decoder.sv]
// 8b/10b decoder; flags symbols outside the code table
`timescale 1ns/100ps
module pcs_decoder (
  code_word_if.dec c
);
  logic       hit6;
  logic       hit4;
  logic       k28;
  logic [3:0] t;
  logic [3:0] p;

  always_comb begin
    hit6   = 1'b0;
    hit4   = 1'b0;
    t      = 4'h0;
    p      = 4'h0;
    c.data = 8'h00;
    k28    = c.sym[9:4] == pcs_pkg::K28_6B || c.sym[9:4] == ~pcs_pkg::K28_6B;
    c.k    = k28;
    if (k28) begin
      hit6        = 1'b1;
      c.data[4:0] = pcs_pkg::K28_LOW;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (c.sym[9:4] == pcs_pkg::TBL6[i] ||
            (($countones(pcs_pkg::TBL6[i]) != 3 || pcs_pkg::TBL6[i] == pcs_pkg::D7_6B) &&
             c.sym[9:4] == ~pcs_pkg::TBL6[i])) begin
          hit6        = 1'b1;
          c.data[4:0] = 5'(i);
        end
      end
    end
    for (int j = 0; j < 8; j++) begin
      t = pcs_pkg::TBL4[j];
      if (k28) begin
        if (j == 7) begin
          t = pcs_pkg::A7_4B;
        end
        p = ($countones(t) != 2 || t == pcs_pkg::X3_4B) ? ~t : t;
        if (c.sym[3:0] == (c.sym[9] ? ~p : p)) begin
          hit4        = 1'b1;
          c.data[7:5] = 3'(j);
        end
      end else if (c.sym[3:0] == t ||
                   (($countones(t) != 2 || t == pcs_pkg::X3_4B) && c.sym[3:0] == ~t) ||
                   (j == 7 && (c.sym[3:0] == pcs_pkg::A7_4B ||
                               c.sym[3:0] == ~pcs_pkg::A7_4B))) begin
        hit4        = 1'b1;
        c.data[7:5] = 3'(j);
      end
    end
    c.bad = !(hit6 && hit4);
  end
endmodule

// [design/serial_lane_pcs_datapath.sv]
// single-lane coding sublayer: align, decode, buffer, encode, serialise
`timescale 1ns/100ps
module serial_lane_pcs_datapath #(
  parameter int STAB_CYCLES = pcs_pkg::STABLE_CYCLES,
  parameter int FIFO_DEPTH  = pcs_pkg::RX_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       recovered_clock,
  input  wire logic       rx_serial_bit,
  input  wire logic       rx_carrier_present,
  input  wire logic       rx_polarity_invert,
  input  wire logic       tx_source_clock,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_control_flag,
  input  wire logic       tx_electrical_idle_force,
  input  wire logic       compliance_disparity_force,
  output logic            tx_serial_bit,
  output logic            tx_serial_idle,
  output logic            rx_source_clock,
  output logic      [7:0] rx_byte_out,
  output logic            rx_control_flag,
  output logic            rx_symbol_valid,
  output logic            phy_completion_status
);
  localparam int CW = $clog2(STAB_CYCLES + 1);
  localparam int AW = $clog2(FIFO_DEPTH);

  typedef logic [AW:0] ptr_t;

  typedef struct packed {
    logic [CW-1:0] stab_cnt;
    logic          stable;
    logic [11:0]   tx_s1;
    logic [11:0]   tx_s2;
    logic          tx_clk_prev;
    logic [7:0]    hold_byte;
    logic          hold_k;
    logic [9:0]    ser;
    logic [3:0]    bit_cnt;
    logic          rd;
    logic          idle;
    logic [2:0]    rclk_cnt;
    logic          rclk;
    ptr_t          wg1;
    ptr_t          wg2;
    ptr_t          rbin;
    ptr_t          rgray;
    logic [7:0]    rx_byte;
    logic          rx_k;
    logic          rx_valid;
  } core_t;

  typedef struct packed {
    logic       rst1;
    logic       rst2;
    logic       car1;
    logic       car2;
    logic       pol1;
    logic       pol2;
    logic [9:0] sr;
    logic [3:0] cnt;
    logic       locked;
    ptr_t       wbin;
    ptr_t       wgray;
    ptr_t       rg1;
    ptr_t       rg2;
  } link_t;

  core_t      cq;
  core_t      cd;
  link_t      lq;
  link_t      ld;
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic       push;
  logic       pop;
  logic       full;
  logic       empty;
  logic       tx_load;
  logic       rx_fall;
  logic       word_rdy;
  logic       comma;
  logic [9:0] sr_n;
  logic [2:0] rclk_per;
  logic [2:0] rclk_hi;

  function automatic ptr_t to_gray(input ptr_t b);
    return b ^ (b >> 1);
  endfunction

  code_word_if enc_c ();
  code_word_if dec_c ();

  pcs_encoder u_enc (
    .c (enc_c)
  );

  pcs_decoder u_dec (
    .c (dec_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link side: recovered clock domain

  assign sr_n      = {lq.sr[8:0], rx_serial_bit ^ lq.pol2};
  assign dec_c.sym = sr_n;
  assign comma     = sr_n == pcs_pkg::COMMA_NEG || sr_n == pcs_pkg::COMMA_POS;
  assign full      = lq.wgray == {~lq.rg2[AW:AW-1], lq.rg2[AW-2:0]};

  always_comb begin
    ld       = lq;
    ld.rst1  = rst_n;
    ld.rst2  = lq.rst1;
    ld.car1  = rx_carrier_present;
    ld.car2  = lq.car1;
    ld.pol1  = rx_polarity_invert;
    ld.pol2  = lq.pol1;
    ld.rg1   = cq.rgray;
    ld.rg2   = lq.rg1;
    word_rdy = 1'b0;
    if (lq.car2) begin
      ld.sr = sr_n;
      if (comma) begin
        ld.locked = 1'b1;
        ld.cnt    = 4'h0;
        word_rdy  = 1'b1;
      end else if (lq.cnt == pcs_pkg::BIT_LAST) begin
        ld.cnt   = 4'h0;
        word_rdy = 1'b1;
      end else begin
        ld.cnt = lq.cnt + 4'h1;
      end
    end else begin
      ld.locked = 1'b0;
    end
    push = word_rdy && (lq.locked || comma) && !dec_c.bad && !full;
    if (push) begin
      ld.wbin  = lq.wbin + 1'b1;
      ld.wgray = to_gray(ld.wbin);
    end
    if (!lq.rst2) begin
      ld      = '0;
      ld.rst1 = rst_n;
      ld.rst2 = lq.rst1;
      push    = 1'b0;
    end
  end

  always_ff @(posedge recovered_clock) begin
    lq <= ld;
  end

  // decoded byte and control flag stored together
  always_ff @(posedge recovered_clock) begin
    if (push) begin
      fifo_mem[lq.wbin[AW-1:0]] <= {dec_c.k, dec_c.data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core side: reference clock domain

  assign empty         = cq.rgray == cq.wg2;
  assign tx_load       = cq.bit_cnt == pcs_pkg::BIT_LAST;
  assign enc_c.data    = cq.hold_byte;
  assign enc_c.k       = cq.hold_k;
  assign enc_c.rd      = cq.tx_s2[pcs_pkg::TXS_COMP] ? 1'b0 : cq.rd;
  assign rclk_per      = cq.stable ? pcs_pkg::RCLK_FAST_PER : pcs_pkg::RCLK_SLOW_PER;
  assign rclk_hi       = cq.stable ? pcs_pkg::RCLK_FAST_HI : pcs_pkg::RCLK_SLOW_HI;

  always_comb begin
    cd       = cq;
    cd.tx_s1 = {tx_source_clock, tx_control_flag, tx_byte_in,
                tx_electrical_idle_force, compliance_disparity_force};
    cd.tx_s2 = cq.tx_s1;
    cd.tx_clk_prev = cq.tx_s2[pcs_pkg::TXS_CLK];
    cd.wg1   = lq.wgray;
    cd.wg2   = cq.wg1;
    cd.idle  = cq.tx_s2[pcs_pkg::TXS_IDLE];
    if (!cq.stable) begin
      if (cq.stab_cnt == CW'(STAB_CYCLES - 1)) begin
        cd.stable = 1'b1;
      end else begin
        cd.stab_cnt = cq.stab_cnt + 1'b1;
      end
    end
    // one byte per MAC clock rise
    if (cq.tx_s2[pcs_pkg::TXS_CLK] && !cq.tx_clk_prev) begin
      cd.hold_byte = cq.tx_s2[pcs_pkg::TXS_BYTE +: 8];
      cd.hold_k    = cq.tx_s2[pcs_pkg::TXS_K];
    end
    if (tx_load) begin
      cd.ser     = enc_c.sym;
      cd.rd      = enc_c.rd_next;
      cd.bit_cnt = 4'h0;
    end else begin
      cd.ser     = {cq.ser[8:0], 1'b0};
      cd.bit_cnt = cq.bit_cnt + 4'h1;
    end
    // rx clock divided from reference; follows any modulation
    if (cq.rclk_cnt >= rclk_per - 3'h1) begin
      cd.rclk_cnt = 3'h0;
    end else begin
      cd.rclk_cnt = cq.rclk_cnt + 3'h1;
    end
    cd.rclk = cd.rclk_cnt >= rclk_per - rclk_hi;
    // data moves on the falling edge
    rx_fall = cq.rclk && !cd.rclk;
    pop     = rx_fall && !empty && cq.stable;
    if (rx_fall) begin
      cd.rx_valid = pop;
    end
    if (pop) begin
      {cd.rx_k, cd.rx_byte} = fifo_mem[cq.rbin[AW-1:0]];
      cd.rbin  = cq.rbin + 1'b1;
      cd.rgray = to_gray(cd.rbin);
    end
    if (!rst_n) begin
      cd = '0;
    end
  end

  always_ff @(posedge clk) begin
    cq <= cd;
  end

  assign tx_serial_bit   = cq.ser[9];
  assign tx_serial_idle  = cq.idle;
  assign rx_source_clock = cq.rclk;
  assign rx_byte_out     = cq.rx_byte;
  assign rx_control_flag = cq.rx_k;
  assign rx_symbol_valid = cq.rx_valid;
  // status high until clocks stable; reset completion
  assign phy_completion_status = !cq.stable;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_fast_rise;
    $rose(rx_source_clock) && cq.stable;
  endsequence

  sequence s_slow_rise;
    $rose(rx_source_clock) && !cq.stable && cq.stab_cnt < CW'(STAB_CYCLES - 8);
  endsequence

  sequence s_comma_in;
    lq.car2 && comma;
  endsequence

  a_stab_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!cq.stable && cq.stab_cnt == CW'(STAB_CYCLES - 1)) |=> !phy_completion_status)
    else $error("stabilisation did not end at its count");

  a_status_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(phy_completion_status) |-> $past(cq.stab_cnt) == CW'(STAB_CYCLES - 1))
    else $error("completion status dropped early");

  a_slow_rclk: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_slow_rise |-> rx_source_clock[*2] ##1 !rx_source_clock[*3])
    else $error("rx clock not at reference rate while stabilising");

  a_fast_rclk: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_fast_rise |=> !rx_source_clock ##1 rx_source_clock)
    else $error("rx clock not at data rate when stable");

  a_rx_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(rx_symbol_valid) |-> $fell(rx_source_clock))
    else $error("rx output moved off the falling edge");

  a_reset_hold: assert property (
    @(posedge clk)
    !rst_n |=> phy_completion_status && !rx_symbol_valid && !rx_source_clock)
    else $error("reset did not hold outputs");

  a_tx_period: assert property (
    @(posedge clk) disable iff (!rst_n)
    tx_load |=> !tx_load[*8] ##1 !tx_load ##1 tx_load)
    else $error("transmit symbol not ten bits long");

  a_tx_capture: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cq.tx_s2[pcs_pkg::TXS_CLK] && !cq.tx_clk_prev) |=>
      cq.hold_byte == $past(cq.tx_s2[pcs_pkg::TXS_BYTE +: 8]))
    else $error("transmit byte not taken on clock rise");

  a_comma_align: assert property (
    @(posedge recovered_clock) disable iff (!lq.rst2)
    s_comma_in |=> lq.locked && lq.cnt == 4'h0)
    else $error("comma did not realign the boundary");

  a_lock_valid: assert property (
    @(posedge recovered_clock) disable iff (!lq.rst2)
    push |-> (lq.locked || comma) && !dec_c.bad)
    else $error("unlocked or bad symbol entered the buffer");

  a_no_carrier: assert property (
    @(posedge recovered_clock) disable iff (!lq.rst2)
    !lq.car2 |=> !lq.locked && $stable(lq.sr))
    else $error("stream moved without carrier");

  a_no_overrun: assert property (
    @(posedge recovered_clock) disable iff (!lq.rst2)
    full |-> !push ##1 $stable(lq.wbin))
    else $error("write into a full buffer");
endmodule

// [bench/mac_model.sv]
// controller-side driver of the transmit and command inputs
`timescale 1ns/100ps
module mac_model (
  input  wire logic       clk,
  output logic            tx_source_clock,
  output logic      [7:0] tx_byte_in,
  output logic            tx_control_flag,
  output logic            tx_electrical_idle_force,
  output logic            compliance_disparity_force,
  output logic            rx_polarity_invert
);
  //////////////////////////////////////////////////////////////////////////////
  // idle commands while held in reset
  initial begin
    tx_source_clock = 1'b0;
    tx_byte_in = 8'h00;
    tx_control_flag = 1'b0;
    tx_electrical_idle_force = 1'b1;
    compliance_disparity_force = 1'b0;
    rx_polarity_invert = 1'b0;
  end

  task automatic set_cmd(input logic idle, input logic comp, input logic pol);
    @(posedge clk);
    #2;
    tx_electrical_idle_force = idle;
    compliance_disparity_force = comp;
    rx_polarity_invert = pol;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // one byte and flag per tx clock
  // rise mid-eye, timed from the shared clock
  task automatic send_byte(input logic [7:0] b, input logic k);
    @(posedge clk);
    #2;
    tx_byte_in = b;
    tx_control_flag = k;
    repeat (3) @(posedge clk);
    #2;
    tx_source_clock = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    tx_source_clock = 1'b0;
  endtask
endmodule

// [bench/tb_serial_lane_pcs_datapath.sv]
// self-checking bench for the serial lane coding sublayer
`timescale 1ns/100ps
module tb_serial_lane_pcs_datapath;
  localparam int STAB = 20;
  logic       clk;
  logic       rst_n;
  logic       rc_raw;
  logic       link_run;
  logic       recovered_clock;
  logic       rx_serial_bit;
  logic       rx_carrier_present;
  logic       tx_source_clock;
  logic [7:0] tx_byte_in;
  logic       tx_control_flag;
  logic       tx_electrical_idle_force;
  logic       compliance_disparity_force;
  logic       rx_polarity_invert;
  logic       tx_serial_bit;
  logic       tx_serial_idle;
  logic       rx_source_clock;
  logic [7:0] rx_byte_out;
  logic       rx_control_flag;
  logic       rx_symbol_valid;
  logic       phy_completion_status;
  logic [8:0] got[$];
  int         errors;
  int         checks;
  logic [9:0] words [4] = '{10'h0FA, 10'h2AA, 10'h305, 10'h155};
  logic [8:0] exp_n [4] = '{9'h1BC, 9'h0B5, 9'h1BC, 9'h04A};
  logic [8:0] exp_i [4] = '{9'h1BC, 9'h04A, 9'h1BC, 9'h0B5};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // link clock runs only through reset and settling, and within frames
  initial begin
    rc_raw = 1'b0;
    #7;
    forever #16 rc_raw = ~rc_raw;
  end
  assign recovered_clock = rc_raw & link_run;

  mac_model u_mac_model (.clk(clk), .tx_source_clock(tx_source_clock),
    .tx_byte_in(tx_byte_in), .tx_control_flag(tx_control_flag),
    .tx_electrical_idle_force(tx_electrical_idle_force),
    .compliance_disparity_force(compliance_disparity_force),
    .rx_polarity_invert(rx_polarity_invert));

  serial_lane_pcs_datapath #(.STAB_CYCLES(STAB), .FIFO_DEPTH(8)) u_serial_lane_pcs_datapath (
    .clk(clk), .rst_n(rst_n), .recovered_clock(recovered_clock),
    .rx_serial_bit(rx_serial_bit), .rx_carrier_present(rx_carrier_present),
    .rx_polarity_invert(rx_polarity_invert), .tx_source_clock(tx_source_clock),
    .tx_byte_in(tx_byte_in), .tx_control_flag(tx_control_flag),
    .tx_electrical_idle_force(tx_electrical_idle_force),
    .compliance_disparity_force(compliance_disparity_force),
    .tx_serial_bit(tx_serial_bit), .tx_serial_idle(tx_serial_idle),
    .rx_source_clock(rx_source_clock), .rx_byte_out(rx_byte_out),
    .rx_control_flag(rx_control_flag), .rx_symbol_valid(rx_symbol_valid),
    .phy_completion_status(phy_completion_status));

  //////////////////////////////////////////////////////////////////////////////
  // MAC logic on rx clock
  always @(posedge rx_source_clock) begin
    if (rx_symbol_valid === 1'b1) begin
      got.push_back({rx_control_flag, rx_byte_out});
    end
  end

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic link_gate(input logic run);
    @(negedge rc_raw);
    link_run = run;
  endtask

  task automatic rx_word(input logic [9:0] w);
    for (int i = 9; i >= 0; i--) begin
      @(posedge rc_raw);
      #2;
      rx_serial_bit = w[i];
    end
  endtask

  task automatic rclk_period(output logic [7:0] n);
    logic p;
    logic armed;
    logic done;
    n = 8'h00;
    armed = 1'b0;
    done = 1'b0;
    p = rx_source_clock;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge clk);
      #1;
      if (armed) n = n + 8'h01;
      if (rx_source_clock === 1'b1 && p === 1'b0) begin
        done = armed;
        armed = 1'b1;
      end
      p = rx_source_clock;
    end
    if (!done) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic tx_seen(input logic [9:0] pat, output logic hit);
    logic [9:0] sh;
    sh = 10'h000;
    hit = 1'b0;
    repeat (60) begin
      @(posedge clk);
      #1;
      sh = {sh[8:0], tx_serial_bit};
      if (sh === pat) hit = 1'b1;
    end
  endtask

  task automatic do_reset;
    logic [7:0] per;
    int n;
    link_gate(1'b1);
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    check("status in reset", phy_completion_status, 1'b1);
    check("valid in reset", rx_symbol_valid, 1'b0);
    rst_n = 1'b1;
    n = 0;
    fork
      rclk_period(per);
      while (phy_completion_status !== 1'b0 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
    join
    check("slow rx clock", per, 8'h05);
    check("settle bound", (n == STAB || n == STAB + 1), 1'b1);
    link_gate(1'b0);
  endtask

  task automatic rx_frame(input logic inv);
    u_mac_model.set_cmd(1'b0, 1'b0, inv);
    got.delete();
    link_gate(1'b1);
    rx_carrier_present = 1'b1;
    for (int i = 0; i < 23; i++) begin
      @(posedge rc_raw);
      #2;
      rx_serial_bit = i[0];
    end
    check("valid before comma", got.size(), 0);
    for (int i = 0; i < 4; i++) rx_word(words[i]);
    rx_carrier_present = 1'b0;
    repeat (4) @(posedge rc_raw);
    link_gate(1'b0);
    rx_serial_bit = ~rx_serial_bit;
    repeat (40) @(posedge clk);
    check("rx byte count", got.size(), 4);
    for (int i = 0; i < 4; i++) check("rx symbol", got[i], inv ? exp_i[i] : exp_n[i]);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] per;
    logic       hit;
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    link_run = 1'b0;
    rx_serial_bit = 1'b0;
    rx_carrier_present = 1'b0;
    do_reset();
    rclk_period(per);
    check("fast rx clock", per, 8'h02);
    check("idle forced", tx_serial_idle, 1'b1);
    u_mac_model.set_cmd(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    check("idle released", tx_serial_idle, 1'b0);
    u_mac_model.send_byte(8'hB5, 1'b0);
    tx_seen(10'h2AA, hit);
    check("tx D21.5", hit, 1'b1);
    u_mac_model.send_byte(8'hBC, 1'b1);
    tx_seen(10'h305, hit);
    check("tx comma plus", hit, 1'b1);
    tx_seen(10'h0FA, hit);
    check("tx comma minus", hit, 1'b1);
    u_mac_model.set_cmd(1'b0, 1'b1, 1'b0);
    repeat (20) @(posedge clk);
    tx_seen(10'h305, hit);
    check("forced disparity", hit, 1'b0);
    u_mac_model.send_byte(8'hBC, 1'b0);
    repeat (20) @(posedge clk);
    tx_seen(10'h0FA, hit);
    check("data not comma", hit, 1'b0);
    u_mac_model.send_byte(8'h4A, 1'b0);
    tx_seen(10'h155, hit);
    check("tx D10.2", hit, 1'b1);
    rx_frame(1'b0);
    rx_frame(1'b1);
    u_mac_model.set_cmd(1'b1, 1'b0, 1'b0);
    do_reset();
    check("idle after reset", tx_serial_idle, 1'b1);
    print_verdict();
  end
endmodule
